// ===== src/ssir_pkg.sv
package ssir_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] SSIR_OFF_XFER_CNT = 8'h00;
	localparam logic [7:0] SSIR_OFF_COMMAND = 8'h0C;
	localparam logic [7:0] SSIR_OFF_BUS_STATUS = 8'h10;
	localparam logic [7:0] SSIR_OFF_INT_REASON = 8'h14;
	localparam logic [7:0] SSIR_OFF_SEQ_PROGRESS = 8'h18;
	localparam logic [7:0] SSIR_OFF_TARGET_ID = 8'h40;
	localparam logic [7:0] SSIR_OFF_CTRL = 8'h44;
	localparam logic [7:0] SSIR_OFF_DMA_STATUS = 8'h54;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int SSIR_ST_INT = 7;
	localparam int SSIR_ST_IOE = 6;
	localparam int SSIR_ST_PE = 5;
	localparam int SSIR_ST_CTZ = 4;
	localparam int SSIR_CMD_DMA = 7;
	localparam int SSIR_CTRL_RST_REPORT = 0;
	localparam int SSIR_CTRL_PARITY1 = 1;
	localparam int SSIR_CTRL_PARITY2 = 2;
	localparam int SSIR_CTRL_ENHANCED = 3;
	localparam int SSIR_DMA_SCSI_INT = 4;
	localparam int SSIR_ID_W = 3;

	// ----------------------------------------
	// reset values and codes
	// ----------------------------------------
	localparam logic [7:0] SSIR_REASON_RST = 8'h00;
	localparam logic [3:0] SSIR_FLAGS_RST = 4'h0;
	localparam logic [3:0] SSIR_CTRL_RST = 4'h0;
	localparam logic [3:0] SSIR_SEQ_RST = 4'h0;
	localparam logic [2:0] SSIR_PHASE_RST = 3'h0;
	localparam logic [6:0] SSIR_CMD_NOP = 7'h00;
	localparam logic [7:0] SSIR_READ_ZERO = 8'h00;

	// bus phase encodings (msg, c/d, i/o)
	typedef enum logic [2:0] {
		SSIR_PH_DATA_OUT = 3'b000,
		SSIR_PH_DATA_IN = 3'b001,
		SSIR_PH_COMMAND = 3'b010,
		SSIR_PH_STATUS = 3'b011,
		SSIR_PH_RSVD0 = 3'b100,
		SSIR_PH_RSVD1 = 3'b101,
		SSIR_PH_MSG_OUT = 3'b110,
		SSIR_PH_MSG_IN = 3'b111
	} ssir_phase_e;

	// events reported by the scsi core, one-cycle pulses
	typedef struct packed {
		logic bus_reset;
		logic bad_command;
		logic disconnect;
		logic service_request;
		logic success;
		logic reselected;
		logic [3:0] seq_state;
	} ssir_int_ev_s;

	typedef struct packed {
		logic dir_conflict;
		logic fifo_overrun;
		logic sync_phase_change;
		logic cmd_overwrite;
		logic parity_error;
		logic count_zero;
		logic cmd_end;
		logic initiator;
		logic idle;
	} ssir_cond_s;

endpackage

// ===== src/ssir_sticky.sv
`timescale 1ns/100ps
// sticky flag, set wins over clear
module ssir_sticky (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// controls
	input wire logic set,
	input wire logic clr,
	// state
	output logic q
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end
endmodule

// ===== src/ssir_reason_queue.sv
`timescale 1ns/100ps
// holds one stacked interrupt behind the pending one
module ssir_reason_queue
	import ssir_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic soft_clr,
	// new events
	input wire logic ev_valid,
	input wire ssir_pkg::ssir_int_ev_s ev_in,
	// pop when first interrupt serviced
	input wire logic pop,
	// held event
	output logic held_valid,
	output ssir_pkg::ssir_int_ev_s held_ev
);
	// single slot; a third event merges into the held one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			held_valid <= 1'b0;
			held_ev <= '0;
		end else if (soft_clr) begin
			held_valid <= 1'b0;
			held_ev <= '0;
		end else if (pop) begin
			// an event in the popping cycle takes the freed slot instead of being lost
			held_valid <= ev_valid;
			held_ev <= ev_valid ? ev_in : ssir_int_ev_s'('0);
		end else if (ev_valid) begin
			held_valid <= 1'b1;
			held_ev <= held_ev | ev_in;
		end
	end
endmodule

// ===== src/ssir_top.sv
// The AHB-Lite slave port was decided locally.
`timescale 1ns/100ps
module ssir_top
	import ssir_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic SOFT_RESET,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// scsi core events and conditions
	input wire ssir_pkg::ssir_int_ev_s CORE_EV,
	input wire ssir_pkg::ssir_cond_s CORE_COND,
	input wire ssir_pkg::ssir_phase_e BUS_PHASE,
	// outputs to core
	output logic [2:0] TARGET_ID,
	output logic [6:0] CMD_CODE,
	output logic CMD_STROBE,
	output logic CMD_ILLEGAL,
	output logic XFER_RELOAD,
	output logic INT_OUT
);
	import ssir_pkg::*;

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic dp_valid_ff;
	logic dp_write_ff;
	logic [7:0] dp_addr_ff;
	wire addr_take = HSEL && HREADY && HTRANS[1];

	// capture address phase; zero wait states, so it stays short
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			dp_valid_ff <= 1'b0;
			dp_write_ff <= 1'b0;
			dp_addr_ff <= 8'h00;
		end else begin
			dp_valid_ff <= addr_take;
			dp_write_ff <= HWRITE;
			dp_addr_ff <= HADDR[7:0];
		end
	end

	// never stall: every register answers in the cycle after its address
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// read strobe at address phase so data is ready in the data phase
	wire rd_take = addr_take && !HWRITE;
	wire rd_reason = rd_take && (HADDR[7:0] == SSIR_OFF_INT_REASON);
	wire wr_go = dp_valid_ff && dp_write_ff;
	wire wr_cmd = wr_go && (dp_addr_ff == SSIR_OFF_COMMAND);
	wire wr_id = wr_go && (dp_addr_ff == SSIR_OFF_TARGET_ID);
	wire wr_ctrl = wr_go && (dp_addr_ff == SSIR_OFF_CTRL);

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	logic [3:0] ctrl_ff;
	logic [2:0] target_id_ff;
	logic [7:0] cmd_ff;

	// soft reset returns control and command to their idle values
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_ff <= SSIR_CTRL_RST;
			cmd_ff <= 8'h00;
		end else if (SOFT_RESET) begin
			ctrl_ff <= SSIR_CTRL_RST;
			cmd_ff <= 8'h00;
		end else begin
			if (wr_ctrl) begin
				ctrl_ff <= HWDATA[3:0];
			end
			if (wr_cmd) begin
				cmd_ff <= HWDATA[7:0];
			end
		end
	end

	// id no reset
	// left out of the reset list on purpose: software value must survive
	always_ff @(posedge SYS_CLK) begin
		if (wr_id) begin
			target_id_ff <= HWDATA[SSIR_ID_W-1:0];
		end
	end

	// mode bits decoded once, read by the phase output select and the parity flag
	wire enhanced = ctrl_ff[SSIR_CTRL_ENHANCED];
	wire parity_on = ctrl_ff[SSIR_CTRL_PARITY1] || ctrl_ff[SSIR_CTRL_PARITY2];

	// ----------------------------------------
	// command decode
	// ----------------------------------------
	// command code decode
	// eighteen legal codes: 00-03 general, 10-17 initiator, 40-45 idle
	wire [6:0] cmd_code = HWDATA[6:0];
	wire cmd_general = (cmd_code <= 7'h03);
	wire cmd_init = (cmd_code >= 7'h10) && (cmd_code <= 7'h17);
	wire cmd_idle_grp = (cmd_code >= 7'h40) && (cmd_code <= 7'h45);
	wire cmd_bad = !(cmd_general || (cmd_init && CORE_COND.initiator) || (cmd_idle_grp && CORE_COND.idle));
	wire cmd_is_dma = HWDATA[SSIR_CMD_DMA];
	wire reload = wr_cmd && cmd_is_dma;

	assign CMD_CODE = cmd_ff[6:0];
	assign TARGET_ID = target_id_ff;

	logic cmd_stb_ff;
	logic cmd_bad_ff;
	logic reload_ff;
	// strobe outputs registered for clean timing to the core
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cmd_stb_ff <= 1'b0;
			cmd_bad_ff <= 1'b0;
			reload_ff <= 1'b0;
		end else begin
			cmd_stb_ff <= wr_cmd && !cmd_bad;
			cmd_bad_ff <= wr_cmd && cmd_bad;
			reload_ff <= reload;
		end
	end
	assign CMD_STROBE = cmd_stb_ff;
	assign CMD_ILLEGAL = cmd_bad_ff;
	assign XFER_RELOAD = reload_ff;

	// ----------------------------------------
	// interrupt reason and stacking
	// ----------------------------------------
	logic int_flag_ff;
	logic [7:0] reason_ff;
	logic [3:0] seq_ff;
	logic held_valid;
	ssir_int_ev_s held_ev;
	ssir_int_ev_s ev_now;

	always_comb begin
		ev_now = CORE_EV;
		ev_now.bus_reset = CORE_EV.bus_reset && ctrl_ff[SSIR_CTRL_RST_REPORT];
		ev_now.bad_command = CORE_EV.bad_command || cmd_bad_ff;
		ev_now.disconnect = CORE_EV.disconnect && (CORE_COND.initiator || CORE_COND.idle);
		ev_now.service_request = CORE_EV.service_request && CORE_COND.initiator;
		ev_now.success = CORE_EV.success && CORE_COND.initiator;
	end

	// seq_state alone never interrupts; it only travels with a reason
	wire ev_any = ev_now.bus_reset || ev_now.bad_command || ev_now.disconnect ||
		ev_now.service_request || ev_now.success || ev_now.reselected;
	// reads without pending interrupt do nothing
	wire service = rd_reason && int_flag_ff;
	// stack while pending
	// an event that meets a servicing read while one is still held must queue
	// behind the held one, or loading the held reasons would swallow it
	wire stack_ev = ev_any && int_flag_ff && (!service || held_valid);
	wire load_held = service && held_valid;
	wire [7:0] ev_bits = {ev_now.bus_reset, ev_now.bad_command, ev_now.disconnect,
		ev_now.service_request, ev_now.success, ev_now.reselected, 2'b00};
	wire [7:0] held_bits = {held_ev.bus_reset, held_ev.bad_command, held_ev.disconnect,
		held_ev.service_request, held_ev.success, held_ev.reselected, 2'b00};

	// one slot is enough: the flag itself stands for the first interrupt
	ssir_reason_queue u_queue (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.soft_clr(SOFT_RESET),
		.ev_valid(stack_ev),
		.ev_in(ev_now),
		.pop(service),
		.held_valid(held_valid),
		.held_ev(held_ev)
	);

	// flag and reason update
	// an event in the servicing cycle is loaded, or queued behind a held one, not lost
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			int_flag_ff <= 1'b0;
			reason_ff <= SSIR_REASON_RST;
			seq_ff <= SSIR_SEQ_RST;
		end else if (SOFT_RESET) begin
			int_flag_ff <= 1'b0;
			reason_ff <= SSIR_REASON_RST;
			seq_ff <= SSIR_SEQ_RST;
		end else if (load_held) begin
			int_flag_ff <= 1'b1;
			reason_ff <= held_bits;
			seq_ff <= held_ev.seq_state;
		end else if (ev_any && (!int_flag_ff || service)) begin
			int_flag_ff <= 1'b1;
			reason_ff <= ev_bits;
			seq_ff <= ev_now.seq_state;
		end else if (service) begin
			int_flag_ff <= 1'b0;
			reason_ff <= SSIR_REASON_RST;
			seq_ff <= SSIR_SEQ_RST;
		end
	end

	assign INT_OUT = int_flag_ff;

	// ----------------------------------------
	// bus-status flags
	// ----------------------------------------
	logic ioe_q;
	logic pe_q;
	logic ctz_q;
	// io-error and parity flags clear on serviced reason read and reset
	// soft reset clears the same flags as a serviced read
	wire flag_clr = service || SOFT_RESET;
	wire ioe_set = CORE_COND.dir_conflict || CORE_COND.fifo_overrun || CORE_COND.cmd_overwrite ||
		(CORE_COND.sync_phase_change && CORE_COND.initiator) ||
		(wr_cmd && (cmd_ff != 8'h00) && !CMD_STROBE);
	wire pe_set = CORE_COND.parity_error && parity_on;

	ssir_sticky u_ioe (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.set(ioe_set),
		.clr(flag_clr),
		.q(ioe_q)
	);

	ssir_sticky u_pe (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.set(pe_set),
		.clr(flag_clr),
		.q(pe_q)
	);

	// count-zero, reload clears, read does not
	// the reason read is deliberately not a clear term here
	ssir_sticky u_ctz (
		.clk(SYS_CLK),
		.rst_n(RESET_N),
		.set(CORE_COND.count_zero),
		.clr(reload || SOFT_RESET),
		.q(ctz_q)
	);

	// ----------------------------------------
	// phase bits
	// ----------------------------------------
	logic [2:0] phase_latch_ff;
	logic latch_closed_ff;

	// latch at command end, reopen on reason read
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			phase_latch_ff <= SSIR_PHASE_RST;
			latch_closed_ff <= 1'b0;
		end else if (service || SOFT_RESET) begin
			latch_closed_ff <= 1'b0;
		// the first command end wins; later ones wait for the reopening read
		end else if (CORE_COND.cmd_end && !latch_closed_ff) begin
			phase_latch_ff <= BUS_PHASE;
			latch_closed_ff <= 1'b1;
		end
	end

	// phase encoding passed through as-is
	// reserved codes are not filtered; software sees what the bus shows
	wire [2:0] phase_out = (enhanced && latch_closed_ff) ? phase_latch_ff : BUS_PHASE;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	// interrupt mirror
	wire [7:0] dma_status = {3'b000, int_flag_ff, 4'h0};
	// bit 3 is reserved and reads as zero
	wire [7:0] bus_status = {int_flag_ff, ioe_q, pe_q, ctz_q, 1'b0, phase_out};
	logic [7:0] rd_mux;

	// write-only and unmapped locations read as zero
	always_comb begin
		case (HADDR[7:0])
			SSIR_OFF_BUS_STATUS: rd_mux = bus_status;
			SSIR_OFF_INT_REASON: rd_mux = reason_ff;
			SSIR_OFF_SEQ_PROGRESS: rd_mux = {4'h0, seq_ff};
			SSIR_OFF_COMMAND: rd_mux = cmd_ff;
			SSIR_OFF_CTRL: rd_mux = {4'h0, ctrl_ff};
			SSIR_OFF_DMA_STATUS: rd_mux = dma_status;
			default: rd_mux = SSIR_READ_ZERO;
		endcase
	end

	logic [31:0] rdata_ff;
	// sampled at address phase, before the read's own clearing takes effect
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rdata_ff <= 32'h0000_0000;
		end else if (rd_take) begin
			rdata_ff <= {24'h00_0000, rd_mux};
		end
	end
	// upper bytes stay zero: one 8-bit register per word
	assign HRDATA = rdata_ff;

endmodule

// ===== sim/ssir_core_model.sv
`timescale 1ns/100ps
// ----
// scsi core stand-in: event pulses, condition pulses, live phase
// ----
module ssir_core_model
	import ssir_pkg::*;
(
	// clock
	input wire logic clk,
	// toward the block
	output ssir_pkg::ssir_int_ev_s ev,
	output ssir_pkg::ssir_cond_s cond,
	output ssir_pkg::ssir_phase_e phase
);
	// quiet core at power-up
	initial begin
		ev = '0;
		cond = '0;
		phase = SSIR_PH_DATA_OUT;
	end
	// one-cycle pulses; mode levels survive so the block sees no glitch on them
	task automatic fire(input ssir_int_ev_s e, input ssir_cond_s c);
		@(posedge clk);
		ev <= e;
		cond <= c | {7'h0, cond.initiator, cond.idle};
		@(posedge clk);
		ev <= '0;
		cond <= {7'h0, cond.initiator, cond.idle};
	endtask
	// initiator and idle are levels held between pulses
	task automatic mode(input logic ini, input logic idl);
		@(posedge clk);
		cond <= {7'h0, ini, idl};
	endtask
	// real bus phase changes only after an edge
	task automatic set_phase(input ssir_phase_e p);
		@(posedge clk);
		phase <= p;
	endtask
endmodule

// ===== sim/ssir_asserts.sv
`timescale 1ns/100ps
module ssir_chk
	import ssir_pkg::*;
(
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	input wire logic SOFT_RESET,
	// bus
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	input wire logic [31:0] HRDATA,
	// core side
	input wire ssir_pkg::ssir_int_ev_s CORE_EV,
	input wire logic [2:0] TARGET_ID,
	input wire logic CMD_ILLEGAL,
	input wire logic CMD_STROBE,
	input wire logic XFER_RELOAD,
	input wire logic INT_OUT
);
	// ----
	// bus decode
	// ----
	logic wr_ff;
	logic [7:0] wa_ff;
	logic [3:0] cause_ff;
	wire acc = HSEL && HREADY && HTRANS[1];
	wire rd10 = acc && !HWRITE && HADDR[7:0] == SSIR_OFF_BUS_STATUS;
	wire rd14 = acc && !HWRITE && HADDR[7:0] == SSIR_OFF_INT_REASON;
	wire rd54 = acc && !HWRITE && HADDR[7:0] == SSIR_OFF_DMA_STATUS;
	wire cwr = wr_ff && wa_ff == SSIR_OFF_COMMAND;
	wire cause = (|CORE_EV[9:4]) || CMD_ILLEGAL || rd14;
	// data-phase tracking and a short history of interrupt causes
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wr_ff <= 1'b0;
			wa_ff <= 8'h00;
			cause_ff <= 4'h0;
		end else begin
			wr_ff <= acc && HWRITE;
			wa_ff <= HADDR[7:0];
			cause_ff <= {cause_ff[2:0], cause};
		end
	end
	// ----
	// properties
	// ----
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N || SOFT_RESET);
	chk_bad_int: assert property (CORE_EV.bad_command |-> ##[1:2] INT_OUT)
		else $error("bad command gave no interrupt");
	chk_reselected_seen_int: assert property (CORE_EV.reselected |-> ##[1:2] INT_OUT)
		else $error("reselection gave no interrupt");
	chk_int_cause: assert property ($rose(INT_OUT) |-> cause_ff != 4'h0)
		else $error("interrupt rose without a cause");
	chk_dma_mirror: assert property (rd54 |=> HRDATA[SSIR_DMA_SCSI_INT] == $past(INT_OUT))
		else $error("dma status bit does not mirror interrupt");
	chk_stat_int: assert property (rd10 |=> HRDATA[31:8] == 24'h00_0000 && HRDATA[7] == $past(INT_OUT))
		else $error("status interrupt bit differs from output");
	chk_reason_set: assert property (rd14 && INT_OUT |=> HRDATA[7:2] != 6'h00)
		else $error("pending interrupt with empty reason");
	chk_reason_idle: assert property (rd14 && !INT_OUT |=> HRDATA[7:0] == 8'h00)
		else $error("reason nonzero with no interrupt");
	chk_tid_write: assert property (wr_ff && wa_ff == SSIR_OFF_TARGET_ID |=> TARGET_ID == $past(HWDATA[2:0]))
		else $error("target id not taken from write");
	chk_dma_reload: assert property (cwr && HWDATA[7:0] == 8'h80 |-> ##[1:2] XFER_RELOAD)
		else $error("dma nop gave no reload");
	chk_bad_code: assert property (cwr && HWDATA[6:0] == 7'h7F |-> ##[1:2] CMD_ILLEGAL)
		else $error("illegal code not flagged");
	chk_good_strobe: assert property (cwr && HWDATA[6:0] == 7'h00 |=> CMD_STROBE)
		else $error("legal command gave no strobe");
	chk_bad_nostrobe: assert property (cwr && HWDATA[6:0] == 7'h7F |=> !CMD_STROBE)
		else $error("illegal command was strobed");
	cover property (rd14 && INT_OUT);
	cover property (XFER_RELOAD);
	cover property (CMD_ILLEGAL);
endmodule

// ===== sim/ssir_tb_top.sv
`timescale 1ns/100ps
module scsi_status_interrupt_regs_tb_top;
	import ssir_pkg::*;
	logic clk, rst_n, soft_rst, hsel, hwrite, hready, hresp, int_o;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] tid;
	logic [6:0] cmd_code;
	ssir_int_ev_s ev;
	ssir_cond_s cond;
	ssir_phase_e ph;
	int n_errors, check_count, cyc;

	ssir_top i_dut (.SYS_CLK(clk), .RESET_N(rst_n), .SOFT_RESET(soft_rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
		.HREADYOUT(hready), .HRESP(hresp), .CORE_EV(ev), .CORE_COND(cond), .BUS_PHASE(ph), .TARGET_ID(tid),
		.CMD_CODE(cmd_code), .CMD_STROBE(), .CMD_ILLEGAL(), .XFER_RELOAD(), .INT_OUT(int_o));
	ssir_core_model i_core (.clk(clk), .ev(ev), .cond(cond), .phase(ph));

	// free-running clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc > 5000) begin
			n_errors++;
			stop_test();
		end
	end
	// ----
	// shared tasks
	// ----
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// single ahb transfer; address held until hready, then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= 32'(a);
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	// write, then let the command pulses land before the next access
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		repeat (3) @(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
		xfer(1'b0, a, 32'h0000_0000);
		chk(nm, 32'(e), rd);
		chk("hresp", 32'h0, 32'(hresp));
	endtask
	task automatic ci(input logic e);
		@(negedge clk);
		chk("int_out", 32'(e), 32'(int_o));
	endtask
	task automatic wait_int();
		for (int k = 0; k < 8 && int_o !== 1'b1; k++)
			@(posedge clk);
		ci(1'b1);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		{hsel, hwrite, soft_rst, rst_n} = 4'h0;
		{haddr, hwdata, rd} = '0;
		htrans = 2'h0;
		{n_errors, check_count, cyc} = '0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		i_core.set_phase(SSIR_PH_STATUS);
		rc(SSIR_OFF_BUS_STATUS, 8'h03, "status reset");
		rc(SSIR_OFF_INT_REASON, 8'h00, "reason reset");
		rc(8'h7C, 8'h00, "unmapped");
		for (int i = 0; i < 8; i++) begin
			i_core.set_phase(ssir_phase_e'(i[2:0]));
			rc(SSIR_OFF_BUS_STATUS, 8'(i), "phase code");
		end
		$display("test reset_phase done");
		wr(SSIR_OFF_COMMAND, 32'h0000_007F);
		chk("cmd code", 32'h7F, 32'(cmd_code));
		wait_int();
		rc(SSIR_OFF_BUS_STATUS, 8'h87, "status int");
		xfer(1'b0, SSIR_OFF_DMA_STATUS, 32'h0000_0000);
		chk("dma int", 32'h1, 32'(rd[4]));
		rc(SSIR_OFF_INT_REASON, 8'h40, "reason bad");
		ci(1'b0);
		rc(SSIR_OFF_BUS_STATUS, 8'h07, "status cleared");
		$display("test bad_command done");
		i_core.mode(1'b1, 1'b0);
		i_core.fire(10'h024, 9'h000);
		wait_int();
		i_core.fire(10'h0C3, 9'h000);
		rc(SSIR_OFF_SEQ_PROGRESS, 8'h04, "seq first");
		rc(SSIR_OFF_INT_REASON, 8'h08, "reason first");
		ci(1'b1);
		rc(SSIR_OFF_SEQ_PROGRESS, 8'h03, "seq stacked");
		rc(SSIR_OFF_INT_REASON, 8'h30, "reason stacked");
		rc(SSIR_OFF_SEQ_PROGRESS, 8'h00, "seq cleared");
		ci(1'b0);
		$display("test stacking done");
		wr(SSIR_OFF_CTRL, 32'h0000_0002);
		i_core.fire(10'h000, 9'h118);
		ci(1'b0);
		rc(SSIR_OFF_BUS_STATUS, 8'h77, "flags set");
		i_core.fire(10'h010, 9'h000);
		wait_int();
		rc(SSIR_OFF_INT_REASON, 8'h04, "reason reselected_seen");
		rc(SSIR_OFF_BUS_STATUS, 8'h17, "count zero kept");
		wr(SSIR_OFF_COMMAND, 32'h0000_0000);
		xfer(1'b0, SSIR_OFF_BUS_STATUS, 32'h0000_0000);
		chk("ctz plain nop", 32'h1, 32'(rd[4]));
		chk("ioe cmd overwrite", 32'h1, 32'(rd[6]));
		wr(SSIR_OFF_COMMAND, 32'h0000_0080);
		xfer(1'b0, SSIR_OFF_BUS_STATUS, 32'h0000_0000);
		chk("ctz dma nop", 32'h0, 32'(rd[4]));
		chk("cmd code dma nop", 32'h00, 32'(cmd_code));
		rc(SSIR_OFF_COMMAND, 8'h80, "command readback");
		wr(SSIR_OFF_CTRL, 32'h0000_0000);
		i_core.fire(10'h000, 9'h010);
		xfer(1'b0, SSIR_OFF_BUS_STATUS, 32'h0000_0000);
		chk("parity off", 32'h0, 32'(rd[5]));
		i_core.fire(10'h200, 9'h000);
		ci(1'b0);
		wr(SSIR_OFF_CTRL, 32'h0000_0001);
		i_core.fire(10'h200, 9'h000);
		wait_int();
		rc(SSIR_OFF_INT_REASON, 8'h80, "reason bus reset");
		$display("test flags done");
		wr(SSIR_OFF_CTRL, 32'h0000_0008);
		i_core.set_phase(SSIR_PH_STATUS);
		i_core.fire(10'h000, 9'h004);
		i_core.set_phase(SSIR_PH_MSG_IN);
		rc(SSIR_OFF_BUS_STATUS, 8'h03, "phase latched");
		i_core.fire(10'h020, 9'h000);
		wait_int();
		rc(SSIR_OFF_INT_REASON, 8'h08, "reason success");
		rc(SSIR_OFF_BUS_STATUS, 8'h07, "phase reopened");
		$display("test latch done");
		wr(SSIR_OFF_TARGET_ID, 32'h0000_0005);
		chk("target id", 32'h5, 32'(tid));
		rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		chk("target id kept", 32'h5, 32'(tid));
		rc(SSIR_OFF_INT_REASON, 8'h00, "reason hard reset");
		rc(SSIR_OFF_BUS_STATUS, 8'h07, "status hard reset");
		i_core.fire(10'h100, 9'h000);
		wait_int();
		i_core.fire(10'h000, 9'h020);
		rc(SSIR_OFF_BUS_STATUS, 8'hC7, "ioe core overwrite");
		@(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		ci(1'b0);
		rc(SSIR_OFF_INT_REASON, 8'h00, "reason soft reset");
		rc(SSIR_OFF_BUS_STATUS, 8'h07, "status soft reset");
		$display("test resets done");
		stop_test();
	end
endmodule

bind ssir_top ssir_chk i_chk (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SOFT_RESET(SOFT_RESET), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HWDATA(HWDATA), .HRDATA(HRDATA),
	.CORE_EV(CORE_EV), .TARGET_ID(TARGET_ID), .CMD_ILLEGAL(CMD_ILLEGAL), .CMD_STROBE(CMD_STROBE),
	.XFER_RELOAD(XFER_RELOAD),
	.INT_OUT(INT_OUT));
